// file: rtl/sram_glue_pkg.sv
package sram_glue_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int DevAddrWidth = 11;
  localparam int CpuAddrWidth = 24;
  localparam int DevAddrLsb = 1;
  localparam int WindowLsb = 12;
  localparam logic [11:0] WindowBaseReset = 12'h000;

  // ---------------------------------------------------------------
  // Lane control encoding
  // ---------------------------------------------------------------
  localparam int LaneCtlWidth = 4;
  localparam logic [3:0] LaneIdle = 4'hf;
  localparam int LaneUpperWrite = 3;
  localparam int LaneLowerWrite = 2;
  localparam int LaneUpperOe = 1;
  localparam int LaneLowerOe = 0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_ACK = 3'b100
  } glue_state_t;

endpackage

// file: rtl/lane_decoder.sv
`timescale 1ns/1ps

// Byte-lane decoder: turns the read/write line and two lane strobes into
// per-lane output enables and write selects, all active low.
module lane_decoder (
  // Processor strobes
  input wire logic readNotWrite,
  input wire logic upper_lane_strobe_n,
  input wire logic lower_lane_strobe_n,
  // Lane controls
  output logic [sram_glue_pkg::LaneCtlWidth-1:0] laneCtl_n
);

  always_comb
  begin
    laneCtl_n = sram_glue_pkg::LaneIdle;
    // Each strobed lane gets an output enable on a read, a write select on a write.
    if (readNotWrite)
    begin
      laneCtl_n[sram_glue_pkg::LaneUpperOe] = upper_lane_strobe_n;
      laneCtl_n[sram_glue_pkg::LaneLowerOe] = lower_lane_strobe_n;
    end
    else
    begin
      laneCtl_n[sram_glue_pkg::LaneUpperWrite] = upper_lane_strobe_n;
      laneCtl_n[sram_glue_pkg::LaneLowerWrite] = lower_lane_strobe_n;
    end
  end

endmodule // lane_decoder

// file: rtl/sram_port_glue.sv
// Notes on behaviour
// - Hold write-block high when not arbitrating
// - Avoid two ports writing one byte together
// - Width grows by parallel devices, one lane
// - Depth: share low address, decode high
// - Byte bus: eleven low address lines direct
// - Word bus: address lines one to eleven
// - Lane decoder: idle high, per-lane enables
// - Upper address places 2K aligned window
// - Qualify window match with address-valid strobe
// - Acknowledge derived from window decode
// - Wide processors use big-endian byte order
`timescale 1ns/1ps

module sram_port_glue #(
  parameter logic [11:0] WindowBase = sram_glue_pkg::WindowBaseReset,
  parameter bit UseAddressValid = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  // Processor bus
  input wire logic [sram_glue_pkg::CpuAddrWidth-1:1] cpuAddr,
  input wire logic address_valid_strobe_n,
  input wire logic readNotWrite,
  input wire logic upper_lane_strobe_n,
  input wire logic lower_lane_strobe_n,
  output logic transfer_acknowledge_n,
  // Arbitration
  input wire logic writeBlockRequest,
  // Memory port, two byte lanes
  output logic [sram_glue_pkg::DevAddrWidth-1:0] memAddr,
  output logic chipEnable_n,
  output logic upper_lane_write_n,
  output logic lower_lane_write_n,
  output logic upper_lane_output_enable_n,
  output logic lower_lane_output_enable_n,
  output logic writeBlock_n
);

  logic [sram_glue_pkg::LaneCtlWidth-1:0] laneCtl_n;
  logic windowHit;
  logic access;
  sram_glue_pkg::glue_state_t state_q;
  sram_glue_pkg::glue_state_t state_d;
  logic [sram_glue_pkg::DevAddrWidth-1:0] memAddr_q;
  logic chipEnable_q;
  logic [sram_glue_pkg::LaneCtlWidth-1:0] laneCtl_q;
  logic writeBlock_q;

  // ---------------------------------------------------------------
  // Window decode
  // ---------------------------------------------------------------
  function automatic logic inWindow(input logic [sram_glue_pkg::CpuAddrWidth-1:1] a);
    inWindow = (a[sram_glue_pkg::CpuAddrWidth-1:sram_glue_pkg::WindowLsb] == WindowBase);
  endfunction

  // Window of 4K bytes (2K words) on a 4K boundary, optionally qualified by address valid.
  assign windowHit = inWindow(cpuAddr) && (!UseAddressValid || !address_valid_strobe_n);
  assign access = windowHit && !(upper_lane_strobe_n && lower_lane_strobe_n);

  // The upper strobe selects the even byte, so the upper lane carries it.
  lane_decoder u_lanes (
    .readNotWrite(readNotWrite),
    .upper_lane_strobe_n(upper_lane_strobe_n),
    .lower_lane_strobe_n(lower_lane_strobe_n),
    .laneCtl_n(laneCtl_n)
  );

  // ---------------------------------------------------------------
  // Access sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sram_glue_pkg::ST_IDLE:
        if (access)
          state_d = sram_glue_pkg::ST_ACCESS;
      sram_glue_pkg::ST_ACCESS:
        if (!access)
          state_d = sram_glue_pkg::ST_IDLE;
        else
          state_d = sram_glue_pkg::ST_ACK;
      sram_glue_pkg::ST_ACK:
        if (!access)
          state_d = sram_glue_pkg::ST_IDLE;
      default:
        state_d = sram_glue_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= sram_glue_pkg::ST_IDLE;
    else if (clkEnable)
      state_q <= state_d;
  end

  // ---------------------------------------------------------------
  // Memory port drive
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      memAddr_q <= '0;
    else if (clkEnable && access)
      // Device address inputs take processor lines one through eleven.
      // Both lanes share these lines; a byte-wide bus would start at line zero.
      memAddr_q <= cpuAddr[sram_glue_pkg::DevAddrLsb +: sram_glue_pkg::DevAddrWidth];
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chipEnable_q <= 1'b0;
      laneCtl_q <= sram_glue_pkg::LaneIdle;
    end
    else if (clkEnable)
    begin
      // Chip enable only while inside the window.
      chipEnable_q <= access;
      // Strobes pass through lane decode; idle when out of window.
      laneCtl_q <= access ? laneCtl_n : sram_glue_pkg::LaneIdle;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      writeBlock_q <= 1'b1;
    else if (clkEnable)
      // Held high unless arbitration blocks writes to keep ports off one byte.
      writeBlock_q <= !writeBlockRequest;
  end

  assign memAddr = memAddr_q;
  assign chipEnable_n = !chipEnable_q;
  assign upper_lane_write_n = laneCtl_q[sram_glue_pkg::LaneUpperWrite];
  assign lower_lane_write_n = laneCtl_q[sram_glue_pkg::LaneLowerWrite];
  assign upper_lane_output_enable_n = laneCtl_q[sram_glue_pkg::LaneUpperOe];
  assign lower_lane_output_enable_n = laneCtl_q[sram_glue_pkg::LaneLowerOe];
  assign writeBlock_n = writeBlock_q;
  // Acknowledge once the access has stood one cycle on the port.
  assign transfer_acknowledge_n = !((state_q == sram_glue_pkg::ST_ACK) && access);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_ce_window: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && !access |=> chipEnable_n)
    else $error("Chip enable asserted outside window.");

  a_ce_inside: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && access |=> !chipEnable_n)
    else $error("Chip enable missing inside window.");

  a_oe_write_excl: assert property (@(posedge core_clk) disable iff (!reset_n)
    !((!upper_lane_write_n || !lower_lane_write_n)
      && (!upper_lane_output_enable_n || !lower_lane_output_enable_n)))
    else $error("Output enable and write select both active.");

  a_read_lane: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && access && readNotWrite && !upper_lane_strobe_n
      |=> !upper_lane_output_enable_n && upper_lane_write_n)
    else $error("Upper lane read not enabled.");

  a_write_lane: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && access && !readNotWrite && !lower_lane_strobe_n
      |=> !lower_lane_write_n && lower_lane_output_enable_n)
    else $error("Lower lane write not selected.");

  a_idle_high: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && upper_lane_strobe_n && lower_lane_strobe_n
      |=> upper_lane_write_n && lower_lane_write_n
        && upper_lane_output_enable_n && lower_lane_output_enable_n)
    else $error("Lane controls not idle with strobes high.");

  a_addr_map: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && access |=> memAddr == $past(cpuAddr[11:1]))
    else $error("Device address not from lines one to eleven.");

  a_ack_timing: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && access && state_q == sram_glue_pkg::ST_IDLE ##1 clkEnable && access
      ##1 access |-> !transfer_acknowledge_n)
    else $error("Acknowledge not given after two cycles.");

  a_block_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable |=> writeBlock_n == !$past(writeBlockRequest))
    else $error("Write block does not follow request.");

  a_write_upper: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && access && !readNotWrite && !upper_lane_strobe_n
      |=> !upper_lane_write_n && upper_lane_output_enable_n)
    else $error("Upper lane write not selected.");

  a_read_lower: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && access && readNotWrite && !lower_lane_strobe_n
      |=> !lower_lane_output_enable_n && lower_lane_write_n)
    else $error("Lower lane read not enabled.");

  a_ack_release: assert property (@(posedge core_clk) disable iff (!reset_n)
    !access |-> transfer_acknowledge_n)
    else $error("Acknowledge given without an access.");

  a_ack_enabled: assert property (@(posedge core_clk) disable iff (!reset_n)
    !transfer_acknowledge_n |-> !chipEnable_n)
    else $error("Acknowledge given while the port is not enabled.");

  a_addr_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEnable && !access |=> $stable(memAddr))
    else $error("Device address moved outside an access.");

  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !clkEnable |=> $stable(memAddr) && $stable(chipEnable_n) && $stable(writeBlock_n))
    else $error("Port drive changed while the clock enable was low.");

endmodule // sram_port_glue

// file: bench/sram_port_model.sv
`timescale 1ns/1ps

module sram_port_model (
  // Port controls
  input wire logic [10:0] memAddr,
  input wire logic chipEnable_n,
  input wire logic upper_lane_write_n,
  input wire logic lower_lane_write_n,
  input wire logic upper_lane_output_enable_n,
  input wire logic lower_lane_output_enable_n,
  input wire logic writeBlock_n,
  // Data lines
  input wire logic [15:0] writeData,
  output logic [15:0] readData
);
  logic [7:0] upperMem [2048];
  logic [7:0] lowerMem [2048];
  initial
  begin
    foreach (upperMem[i])
    begin
      upperMem[i] = 8'h00;
      lowerMem[i] = 8'h00;
    end
  end
  // A port completes its own write only while write block is high; a block stops writes only.
  // Writes wait until the lines settle, so edges in one step cannot misplace a byte.
  always @(memAddr or chipEnable_n or upper_lane_write_n or lower_lane_write_n or writeBlock_n
    or writeData)
  begin
    #1;
    if (!chipEnable_n && writeBlock_n && !upper_lane_write_n)
      upperMem[memAddr] = writeData[15:8];
    if (!chipEnable_n && writeBlock_n && !lower_lane_write_n)
      lowerMem[memAddr] = writeData[7:0];
  end
  // Released lines show the inverse of the stored byte rather than a held value.
  always @*
  begin
    readData[15:8] = ~upperMem[memAddr];
    readData[7:0] = ~lowerMem[memAddr];
    if (!chipEnable_n && !upper_lane_output_enable_n)
      readData[15:8] = upperMem[memAddr];
    if (!chipEnable_n && !lower_lane_output_enable_n)
      readData[7:0] = lowerMem[memAddr];
  end
endmodule // sram_port_model

// file: bench/multiport_sram_cpu_port_glue_tb_top.sv
`timescale 1ns/1ps

module multiport_sram_cpu_port_glue_tb_top;
  localparam logic [11:0] Base = 12'h05a3;
  logic core_clk = 1'b0, reset_n = 1'b0, clkEnable = 1'b0, rnw = 1'b1;
  logic [23:1] cpuAddr = '0;
  logic avs_n = 1'b1, ust_n = 1'b1, lst_n = 1'b1, blkReq = 1'b0, ack_n, ce_n, blk_n;
  logic uw_n, lw_n, uoe_n, loe_n, expCe, expBlk, ceFree_n, expCeFree;
  logic [10:0] memAddr, expAddr;
  logic [15:0] wdata = '0, rdata;
  logic [3:0] expLane;
  logic [7:0] bmU [2048], bmL [2048];
  int fails = 0, check_count = 0, cnt, seed = 35;
  logic [31:0] r;

  sram_port_glue #(.WindowBase(Base), .UseAddressValid(1'b1)) DUT (.core_clk(core_clk),
    .reset_n(reset_n), .clkEnable(clkEnable), .cpuAddr(cpuAddr),
    .address_valid_strobe_n(avs_n), .readNotWrite(rnw), .upper_lane_strobe_n(ust_n),
    .lower_lane_strobe_n(lst_n), .transfer_acknowledge_n(ack_n), .writeBlockRequest(blkReq),
    .memAddr(memAddr), .chipEnable_n(ce_n), .upper_lane_write_n(uw_n),
    .lower_lane_write_n(lw_n), .upper_lane_output_enable_n(uoe_n),
    .lower_lane_output_enable_n(loe_n), .writeBlock_n(blk_n));
  sram_port_model partner (.memAddr(memAddr), .chipEnable_n(ce_n), .upper_lane_write_n(uw_n),
    .lower_lane_write_n(lw_n), .upper_lane_output_enable_n(uoe_n),
    .lower_lane_output_enable_n(loe_n), .writeBlock_n(blk_n), .writeData(wdata),
    .readData(rdata));
  // Same window with the address-valid qualification left out.
  sram_port_glue #(.WindowBase(Base), .UseAddressValid(1'b0)) DUT_free (.core_clk(core_clk),
    .reset_n(reset_n), .clkEnable(clkEnable), .cpuAddr(cpuAddr),
    .address_valid_strobe_n(avs_n), .readNotWrite(rnw), .upper_lane_strobe_n(ust_n),
    .lower_lane_strobe_n(lst_n), .transfer_acknowledge_n(), .writeBlockRequest(blkReq),
    .memAddr(), .chipEnable_n(ceFree_n), .upper_lane_write_n(), .lower_lane_write_n(),
    .upper_lane_output_enable_n(), .lower_lane_output_enable_n(), .writeBlock_n());

  always #20 core_clk = ~core_clk;

  function automatic logic inWin();
    return cpuAddr[23:12] == Base && !avs_n && !(ust_n && lst_n);
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt = 0; expCe = 1; expLane = 4'hf; expAddr = '0; expBlk = 1;
      expCeFree = 1'b1;
    end
    else if (clkEnable)
    begin
      cnt = inWin() ? (cnt == 2 ? 2 : cnt + 1) : 0;
      expCe = !inWin();
      expLane = inWin() ? {rnw | ust_n, rnw | lst_n, !rnw | ust_n, !rnw | lst_n} : 4'hf;
      if (inWin())
        expAddr = cpuAddr[11:1];
      expBlk = !blkReq;
      expCeFree = !(cpuAddr[23:12] == Base && !(ust_n && lst_n));
    end
  end

  always @(negedge core_clk)
  begin
    cmp(ce_n, expCe);
    cmp({uw_n, lw_n, uoe_n, loe_n}, expLane);
    cmp(memAddr, expAddr);
    cmp(blk_n, expBlk);
    cmp(ceFree_n, expCeFree);
    cmp(ack_n, !(inWin() && cnt == 2));
    if (!expCe && !expLane[1])
      cmp(rdata[15:8], bmU[expAddr]);
    if (!expCe && !expLane[0])
      cmp(rdata[7:0], bmL[expAddr]);
    if (!expCe && expBlk && !expLane[3])
      bmU[expAddr] = wdata[15:8];
    if (!expCe && expBlk && !expLane[2])
      bmL[expAddr] = wdata[7:0];
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial
  begin
    foreach (bmU[i])
    begin
      bmU[i] = 8'h00;
      bmL[i] = 8'h00;
    end
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3000)
    begin
      @(posedge core_clk);
      r = $random(seed);
      if (r[31:30] == 2'b00)
      begin
        cpuAddr <= {(r[1:0] != 0) ? Base : r[27:16], 8'h00, r[4:2]};
        avs_n <= r[5] & r[6];
        rnw <= r[7];
        ust_n <= r[8];
        lst_n <= r[9];
        blkReq <= r[10] & r[11];
        clkEnable <= r[12] | r[13] | r[14];
        wdata <= 16'($random(seed));
      end
    end
    results();
  end

  // A hang is cut short well past the span of the stimulus loop.
  initial
  begin
    repeat (5000) @(posedge core_clk);
    fails++;
    results();
  end
endmodule // multiport_sram_cpu_port_glue_tb_top
